// ===== dmee_cfg.svh
// Named constants for the data memory and EEPROM access block.
`ifndef DMEE_CFG_SVH
`define DMEE_CFG_SVH
// ==========================================================
// Data space map
`define DMEE_RF_SIZE     32
`define DMEE_IO_SIZE     64
`define DMEE_XIO_SIZE    160
`define DMEE_IO_BASE     16'h0020
`define DMEE_XIO_BASE    16'h0060
`define DMEE_SRAM_BASE   16'h0100
`define DMEE_UNMAPPED    8'hFF
`define DMEE_PTR_X       5'h1A
`define DMEE_PTR_Y       5'h1C
`define DMEE_PTR_Z       5'h1E
// ==========================================================
// EEPROM access registers, standard I/O indices
`define DMEE_IO_EECTL    6'h1F
`define DMEE_IO_EEDATA   6'h20
`define DMEE_IO_EEADRL   6'h21
`define DMEE_IO_EEADRH   6'h22
`define DMEE_B_RD        0
`define DMEE_B_WR        1
`define DMEE_B_ARM       2
`define DMEE_B_PM        4
`define DMEE_PM_ATOMIC   2'h0
`define DMEE_PM_ERASE    2'h1
`define DMEE_PM_WRITE    2'h2
`define DMEE_PM_RSVD     2'h3
`define DMEE_ERASED      8'hFF
// ==========================================================
// Timing
`define DMEE_ARM_CYC     3'h4
`define DMEE_RD_STALL    3'h4
`define DMEE_WR_STALL    3'h2
`define DMEE_CLK_MHZ     50
`define DMEE_T_ATOMIC_US 3400
`define DMEE_T_SPLIT_US  1800
`define DMEE_WCNT_W      18
// ==========================================================
// Controller register offsets and command fields
`define DMEE_WB_ADDR     8'h00
`define DMEE_WB_CTL      8'h04
`define DMEE_WB_STAT     8'h08
`define DMEE_C_WE        8
`define DMEE_C_MODE      9
`define DMEE_C_PTR       12
`define DMEE_C_DISP      14
`define DMEE_C_SEQ       30
`define DMEE_C_GO        31
`define DMEE_S_BUSY      8
`define DMEE_S_ERR       9
`define DMEE_IO_LIMIT    16'h0040
`endif

// ===== dmee_pkg.sv
// Types shared by both ends of the data memory and EEPROM access block.
package dmee_pkg;
   // ==========================================================
   // Addressing modes
   typedef enum logic [2:0] {
      DMEE_M_DIRECT  = 3'h0,
      DMEE_M_IND     = 3'h1,
      DMEE_M_DISP    = 3'h2,
      DMEE_M_PREDEC  = 3'h3,
      DMEE_M_POSTINC = 3'h4,
      DMEE_M_IO      = 3'h5
   } dmee_mode_e;

   typedef enum logic [1:0] {
      DMEE_D_IDLE  = 2'h0,
      DMEE_D_ACC   = 2'h1,
      DMEE_D_STALL = 2'h3
   } dmee_dst_e;

   typedef enum logic {
      DMEE_H_IDLE = 1'h0,
      DMEE_H_REQ  = 1'h1
   } dmee_hst_e;

   typedef struct packed {
      dmee_dst_e   st;
      logic        ack;
      logic [7:0]  rdata;
      logic        we;
      logic [15:0] ea;
      logic [7:0]  wdata;
      logic        ptr_upd;
      logic [4:0]  ptr_idx;
      logic [15:0] ptr_new;
      logic [2:0]  stall;
      logic [8:0]  eeaddr;
      logic [7:0]  eeprom_data_byte;
      logic [1:0]  pm;
      logic        arm;
      logic [2:0]  armcnt;
      logic        busy;
      logic        done;
      logic [17:0] wcnt;
      logic [1:0]  wmode;
      logic [7:0]  wbyte;
   } dmee_dev_s;

   typedef struct packed {
      dmee_hst_e   st;
      logic        phase2;
      logic [15:0] addr;
      logic [31:0] cmd;
      logic        err;
      logic [7:0]  rdata;
      logic        ack;
      logic [31:0] dat;
      logic        req;
      logic        b_we;
      dmee_mode_e  b_mode;
      logic [1:0]  b_ptr;
      logic [5:0]  b_disp;
      logic [15:0] b_addr;
      logic [7:0]  b_wdata;
   } dmee_host_s;
endpackage

// ===== dmee_if.sv
// Data access link between the processor-side controller and the memory block.
`timescale 1ns/1ps
interface dmee_if;
   import dmee_pkg::*;
   logic        req;
   logic        we;
   dmee_mode_e  mode;
   logic [1:0]  ptr;
   logic [5:0]  disp;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        ack;
   logic [7:0]  rdata;
   modport dev (input req, we, mode, ptr, disp, addr, wdata, output ack, rdata);
   modport cpu (output req, we, mode, ptr, disp, addr, wdata, input ack, rdata);
endinterface

// ===== dmee_dev.sv
// Data space decoder, memories and EEPROM access port.
`timescale 1ns/1ps
`include "dmee_cfg.svh"
module dmee_dev
   import dmee_pkg::*;
#(
   parameter int SRAM_BYTES = 512,
   parameter int EE_BYTES   = 512,
   parameter int T_ATOM_CYC = `DMEE_T_ATOMIC_US * `DMEE_CLK_MHZ,
   parameter int T_SPLT_CYC = `DMEE_T_SPLIT_US * `DMEE_CLK_MHZ
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Processor link
   dmee_if.dev       bus,
   // Status
   output logic      ee_busy_o,
   output logic      ee_done_o
);
   localparam int SAW = $clog2(SRAM_BYTES);
   localparam int EAW = $clog2(EE_BYTES);

   // Unsupported sizes are refused while the design is built, not later in a run.
   if (EE_BYTES != 256 && EE_BYTES != 512) begin : g_ee_chk
      $error("EE_BYTES must be 256 or 512");
   end
   if (SRAM_BYTES < 2 || (1 << SAW) != SRAM_BYTES || SRAM_BYTES > 32'hFF00) begin : g_sram_chk
      $error("SRAM_BYTES must be a power of two that fits the data space");
   end
   if (T_ATOM_CYC < 2 || T_SPLT_CYC < 2 || T_ATOM_CYC >= (1 << `DMEE_WCNT_W) ||
       T_SPLT_CYC >= (1 << `DMEE_WCNT_W)) begin : g_time_chk
      $error("write durations do not fit the write timer");
   end

   // ==========================================================
   // Memories
   logic [7:0] rf_mem   [0:`DMEE_RF_SIZE-1];
   logic [7:0] io_mem   [0:`DMEE_IO_SIZE-1];
   logic [7:0] xio_mem  [0:`DMEE_XIO_SIZE-1];
   logic [7:0] sram_mem [0:SRAM_BYTES-1];
   logic [7:0] ee_mem   [0:EE_BYTES-1];

   localparam dmee_dev_s RST = '{st: DMEE_D_IDLE, wmode: `DMEE_PM_ATOMIC, pm: `DMEE_PM_ATOMIC, default: '0};

   dmee_dev_s   s_r;
   dmee_dev_s   s_nxt;
   logic        rf_we;
   logic        io_we;
   logic        xio_we;
   logic        sram_we;
   logic        ee_we;
   logic [7:0]  ee_wd;
   logic [4:0]  pidx;
   logic [15:0] pval;
   logic [15:0] ioff;
   logic [15:0] xoff;
   logic [15:0] soff;
   logic [7:0]  rd;

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt   = s_r;
      rf_we   = 1'b0;
      io_we   = 1'b0;
      xio_we  = 1'b0;
      sram_we = 1'b0;
      ee_we   = 1'b0;
      rd      = 8'h00;
      s_nxt.ack  = 1'b0;
      s_nxt.done = 1'b0;
      ioff = s_r.ea - `DMEE_IO_BASE;
      xoff = s_r.ea - `DMEE_XIO_BASE;
      soff = s_r.ea - `DMEE_SRAM_BASE;
      case (bus.ptr)
         2'h0:    pidx = `DMEE_PTR_X;
         2'h1:    pidx = `DMEE_PTR_Y;
         default: pidx = `DMEE_PTR_Z;
      endcase
      pval = {rf_mem[pidx + 5'h01], rf_mem[pidx]};

      if (s_r.arm) begin
         if (s_r.armcnt == 3'h1)
            s_nxt.arm = 1'b0;
         s_nxt.armcnt = s_r.armcnt - 3'h1;
      end
      // The array is only touched when the timer expires; it gets wbyte latched at start, ANDed with the old byte in write mode, or 0xFF on erase.
      if (s_r.busy) begin
         if (s_r.wcnt == 18'h00001) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            ee_we      = 1'b1;
         end
         s_nxt.wcnt = s_r.wcnt - 18'h00001;
      end
      case (s_r.wmode)
         `DMEE_PM_ERASE: ee_wd = `DMEE_ERASED;
         `DMEE_PM_WRITE: ee_wd = ee_mem[s_r.eeaddr[EAW-1:0]] & s_r.wbyte;
         default:        ee_wd = s_r.wbyte;
      endcase

      case (s_r.st)
         DMEE_D_IDLE: begin
            if (bus.req && !s_r.ack) begin
               s_nxt.st      = DMEE_D_ACC;
               s_nxt.we      = bus.we;
               s_nxt.wdata   = bus.wdata;
               s_nxt.ptr_idx = pidx;
               s_nxt.ptr_upd = 1'b0;
               s_nxt.ptr_new = pval;
               case (bus.mode)
                  DMEE_M_IND:  s_nxt.ea = pval;
                  DMEE_M_DISP: s_nxt.ea = pval + {10'h000, bus.disp};
                  DMEE_M_PREDEC: begin
                     s_nxt.ea      = pval - 16'h0001;
                     s_nxt.ptr_new = pval - 16'h0001;
                     s_nxt.ptr_upd = 1'b1;
                  end
                  DMEE_M_POSTINC: begin
                     s_nxt.ea      = pval;
                     s_nxt.ptr_new = pval + 16'h0001;
                     s_nxt.ptr_upd = 1'b1;
                  end
                  DMEE_M_IO: s_nxt.ea = `DMEE_IO_BASE + {10'h000, bus.addr[5:0]};
                  default:   s_nxt.ea = bus.addr;
               endcase
            end
         end
         DMEE_D_ACC: begin
            s_nxt.st  = DMEE_D_IDLE;
            s_nxt.ack = 1'b1;
            if (s_r.ea < `DMEE_IO_BASE) begin
               rd    = rf_mem[s_r.ea[4:0]];
               rf_we = s_r.we;
            end else if (s_r.ea < `DMEE_XIO_BASE) begin
               case (ioff[5:0])
                  `DMEE_IO_EECTL: begin
                     rd = {2'h0, s_r.pm, 1'b0, s_r.arm, s_r.busy, 1'b0};
                     if (s_r.we) begin
                        if (!s_r.busy)
                           s_nxt.pm = s_r.wdata[`DMEE_B_PM+1:`DMEE_B_PM];
                        if (s_r.wdata[`DMEE_B_ARM]) begin
                           s_nxt.arm    = 1'b1;
                           s_nxt.armcnt = `DMEE_ARM_CYC;
                        end
                        if (s_r.wdata[`DMEE_B_WR] && s_r.arm && !s_r.busy && s_r.pm != `DMEE_PM_RSVD) begin
                           s_nxt.busy  = 1'b1;
                           s_nxt.wmode = s_r.pm;
                           s_nxt.wbyte = s_r.eeprom_data_byte;
                           s_nxt.wcnt  = (s_r.pm == `DMEE_PM_ATOMIC) ? T_ATOM_CYC[17:0] : T_SPLT_CYC[17:0];
                           s_nxt.stall = `DMEE_WR_STALL;
                           s_nxt.st    = DMEE_D_STALL;
                           s_nxt.ack   = 1'b0;
                        end else if (s_r.wdata[`DMEE_B_RD] && !s_r.busy) begin
                           s_nxt.eeprom_data_byte  = ee_mem[s_r.eeaddr[EAW-1:0]];
                           s_nxt.stall = `DMEE_RD_STALL;
                           s_nxt.st    = DMEE_D_STALL;
                           s_nxt.ack   = 1'b0;
                        end
                     end
                  end
                  `DMEE_IO_EEDATA: begin
                     rd = s_r.eeprom_data_byte;
                     if (s_r.we)
                        s_nxt.eeprom_data_byte = s_r.wdata;
                  end
                  `DMEE_IO_EEADRL: begin
                     rd = s_r.eeaddr[7:0];
                     if (s_r.we && !s_r.busy)
                        s_nxt.eeaddr[7:0] = s_r.wdata;
                  end
                  `DMEE_IO_EEADRH: begin
                     rd = {7'h00, s_r.eeaddr[8]};
                     if (s_r.we && !s_r.busy)
                        s_nxt.eeaddr[8] = s_r.wdata[0];
                  end
                  default: begin
                     rd    = io_mem[ioff[5:0]];
                     io_we = s_r.we;
                  end
               endcase
            end else if (s_r.ea < `DMEE_SRAM_BASE) begin
               rd     = xio_mem[xoff[7:0]];
               xio_we = s_r.we;
            end else if (soff < SRAM_BYTES) begin
               rd      = sram_mem[soff[SAW-1:0]];
               sram_we = s_r.we;
            end else begin
               rd = `DMEE_UNMAPPED;
            end
            if (!s_r.we)
               s_nxt.rdata = rd;
         end
         DMEE_D_STALL: begin
            if (s_r.stall == 3'h1) begin
               s_nxt.st  = DMEE_D_IDLE;
               s_nxt.ack = 1'b1;
            end
            s_nxt.stall = s_r.stall - 3'h1;
         end
         default: s_nxt.st = DMEE_D_IDLE;
      endcase
   end

   // ==========================================================
   // Registers
   // The address is given a defined reset value even though software must load it first.
   always_ff @(posedge clk_i) begin
      if (!rstn_i)
         s_r <= RST;
      else
         s_r <= s_nxt;
   end

   // Memory arrays carry no reset.
   always_ff @(posedge clk_i) begin
      if (rf_we)
         rf_mem[s_r.ea[4:0]] <= s_r.wdata;
      // The pointer update is applied after a data write so the pointer wins on overlap.
      if (s_r.st == DMEE_D_ACC && s_r.ptr_upd) begin
         rf_mem[s_r.ptr_idx]         <= s_r.ptr_new[7:0];
         rf_mem[s_r.ptr_idx + 5'h01] <= s_r.ptr_new[15:8];
      end
      if (io_we)
         io_mem[ioff[5:0]] <= s_r.wdata;
      if (xio_we)
         xio_mem[xoff[7:0]] <= s_r.wdata;
      if (sram_we)
         sram_mem[soff[SAW-1:0]] <= s_r.wdata;
      if (ee_we)
         ee_mem[s_r.eeaddr[EAW-1:0]] <= ee_wd;
   end

   assign bus.ack   = s_r.ack;
   assign bus.rdata = s_r.rdata;
   assign ee_busy_o = s_r.busy;
   assign ee_done_o = s_r.done;
endmodule // dmee_dev

// ===== dmee_host.sv
// Processor-side controller: Wishbone command registers driving the data access link.
`timescale 1ns/1ps
`include "dmee_cfg.svh"
module dmee_host
   import dmee_pkg::*;
#(
   parameter int EE_BYTES = 512
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Data access link
   dmee_if.cpu              bus
);
   if (EE_BYTES != 256 && EE_BYTES != 512) begin : g_ee_chk
      $error("EE_BYTES must be 256 or 512");
   end

   localparam dmee_host_s RST = '{st: DMEE_H_IDLE, b_mode: DMEE_M_DIRECT, default: '0};

   dmee_host_s  s_r;
   dmee_host_s  s_nxt;
   logic [31:0] mask;
   logic [31:0] ctl;
   logic [15:0] adr;
   logic        hit;

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      hit   = wb_cyc_i && wb_stb_i;
      mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      ctl   = (s_r.cmd & ~mask) | (wb_dat_i & mask);
      adr   = (s_r.addr & ~mask[15:0]) | (wb_dat_i[15:0] & mask[15:0]);
      s_nxt.ack = hit && !s_r.ack;
      if (hit && !s_r.ack) begin
         case (wb_adr_i)
            `DMEE_WB_ADDR: s_nxt.dat = {16'h0000, s_r.addr};
            `DMEE_WB_CTL:  s_nxt.dat = {1'b0, s_r.cmd[30:0]};
            `DMEE_WB_STAT: s_nxt.dat = {22'h000000, s_r.err, s_r.st == DMEE_H_REQ, s_r.rdata};
            default:       s_nxt.dat = 32'h00000000;
         endcase
      end
      // Writes land on the edge at which the master sees ack.
      if (hit && s_r.ack && wb_we_i) begin
         if (wb_adr_i == `DMEE_WB_ADDR && s_r.st == DMEE_H_IDLE)
            s_nxt.addr = adr;
         if (wb_adr_i == `DMEE_WB_CTL && s_r.st == DMEE_H_IDLE) begin
            s_nxt.cmd = {1'b0, ctl[30:0]};
            if (ctl[`DMEE_C_GO]) begin
               s_nxt.b_we    = ctl[`DMEE_C_WE];
               s_nxt.b_mode  = dmee_mode_e'(ctl[`DMEE_C_MODE+2:`DMEE_C_MODE]);
               s_nxt.b_ptr   = ctl[`DMEE_C_PTR+1:`DMEE_C_PTR];
               s_nxt.b_disp  = ctl[`DMEE_C_DISP+5:`DMEE_C_DISP];
               s_nxt.b_addr  = s_r.addr;
               s_nxt.b_wdata = ctl[7:0];
               s_nxt.phase2  = 1'b0;
               s_nxt.err     = 1'b0;
               if (ctl[`DMEE_C_SEQ]) begin
                  s_nxt.b_we    = 1'b1;
                  s_nxt.b_mode  = DMEE_M_IO;
                  s_nxt.b_addr  = {10'h000, `DMEE_IO_EECTL};
                  s_nxt.b_wdata = (ctl[7:0] & ~(8'h01 << `DMEE_B_WR)) | (8'h01 << `DMEE_B_ARM);
                  s_nxt.phase2  = 1'b1;
               end
               if (EE_BYTES == 256 && ctl[`DMEE_C_WE] && ((dmee_mode_e'(ctl[11:9]) == DMEE_M_IO &&
                   s_r.addr == {10'h000, `DMEE_IO_EEADRH}) || (dmee_mode_e'(ctl[11:9]) == DMEE_M_DIRECT &&
                   s_r.addr == `DMEE_IO_BASE + {10'h000, `DMEE_IO_EEADRH})))
                  s_nxt.b_wdata[0] = 1'b0;
               if (dmee_mode_e'(ctl[11:9]) == DMEE_M_IO && s_r.addr >= `DMEE_IO_LIMIT && !ctl[`DMEE_C_SEQ]) begin
                  s_nxt.err = 1'b1;
               end else begin
                  s_nxt.req = 1'b1;
                  s_nxt.st  = DMEE_H_REQ;
               end
            end
         end
      end
      case (s_r.st)
         DMEE_H_IDLE: s_nxt.req = s_nxt.req;
         DMEE_H_REQ: begin
            if (bus.ack) begin
               if (s_r.phase2) begin
                  // The strobe follows at once, well inside the arm window.
                  s_nxt.b_wdata = (s_r.b_wdata & ~(8'h01 << `DMEE_B_ARM)) | (8'h01 << `DMEE_B_WR);
                  s_nxt.phase2  = 1'b0;
               end else begin
                  s_nxt.req   = 1'b0;
                  s_nxt.rdata = bus.rdata;
                  s_nxt.st    = DMEE_H_IDLE;
               end
            end
         end
         default: s_nxt.st = DMEE_H_IDLE;
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (!rstn_i)
         s_r <= RST;
      else
         s_r <= s_nxt;
   end

   assign wb_dat_o  = s_r.dat;
   assign wb_ack_o  = s_r.ack;
   assign bus.req   = s_r.req;
   assign bus.we    = s_r.b_we;
   assign bus.mode  = s_r.b_mode;
   assign bus.ptr   = s_r.b_ptr;
   assign bus.disp  = s_r.b_disp;
   assign bus.addr  = s_r.b_addr;
   assign bus.wdata = s_r.b_wdata;
endmodule // dmee_host

// ===== dmee_chk_sva.sv
// Concurrent checks on the link between the controller and the memory block.
`timescale 1ns/1ps
module dmee_chk
   import dmee_pkg::*;
#(
   parameter int T_ATOM_CYC = 20,
   parameter int T_SPLT_CYC = 10
) (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rstn_i,
   // Link
   input wire logic        req,
   input wire logic        we,
   input wire dmee_mode_e  mode,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        ack,
   input wire logic [7:0]  rdata,
   // Status
   input wire logic        ee_busy_o,
   input wire logic        ee_done_o
);
   logic        ctl_hit;
   logic [17:0] bcnt_r;
   logic [17:0] bcnt_nxt;
   assign ctl_hit = (mode == DMEE_M_IO) && (addr[5:0] == 6'h1F);
   // A cycle count is used because the write time is far beyond a repetition bound.
   always_comb begin
      bcnt_nxt = ee_busy_o ? bcnt_r + 18'h1 : 18'h0;
   end
   always_ff @(posedge clk_i) begin
      bcnt_r <= rstn_i ? bcnt_nxt : 18'h0;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("link ack longer than one cycle");
   read_lat_a: assert property ($rose(req) && !we |-> !ack [*2] ##1 ack)
      else $error("read not answered in two cycles");
   ee_read_a: assert property ($rose(req) && we && ctl_hit && wdata[0] && !wdata[1] && !ee_busy_o
      |-> !ack [*6] ##1 ack)
      else $error("eeprom read stall wrong");
   wr_start_a: assert property ($rose(ee_busy_o) |-> (req && we && ctl_hit && wdata[1]) ##[0:3] ack)
      else $error("write started without strobe access");
   done_fall_a: assert property ($fell(ee_busy_o) |-> ee_done_o)
      else $error("busy fell without done");
   busy_len_a: assert property ($fell(ee_busy_o) |-> bcnt_r == T_ATOM_CYC || bcnt_r == T_SPLT_CYC)
      else $error("write duration wrong");
   done_pulse_a: assert property (ee_done_o |=> !ee_done_o)
      else $error("done longer than one cycle");
   rdata_hold_a: assert property ($changed(rdata) |-> ack && !we)
      else $error("read data changed outside a read");
   cover property ($rose(req) && !we ##2 ack);
   cover property ($rose(ee_busy_o));
   cover property (ee_done_o);
endmodule // dmee_chk

// ===== testbench.sv
// Self-checking bench: controller and memory block joined over the link.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
   import dmee_pkg::*;
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        busy;
   logic        done;
   logic [31:0] st;
   int          bad_count = 0;
   int          checks = 0;
   dmee_if bus_if();
   dmee_dev #(.T_ATOM_CYC(80), .T_SPLT_CYC(40)) dmee_dev_i(.clk_i(clk_i), .rstn_i(rstn_i), .bus(bus_if.dev),
      .ee_busy_o(busy), .ee_done_o(done));
   dmee_host dmee_host_i(.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus(bus_if.cpu));
   dmee_chk #(.T_ATOM_CYC(80), .T_SPLT_CYC(40)) dmee_chk_i(.clk_i(clk_i), .rstn_i(rstn_i),
      .req(bus_if.req), .we(bus_if.we), .mode(bus_if.mode), .addr(bus_if.addr), .wdata(bus_if.wdata),
      .ack(bus_if.ack), .rdata(bus_if.rdata), .ee_busy_o(busy), .ee_done_o(done));
   always #10 clk_i = ~clk_i;
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         bad_count++;
         $display("[FAIL] wait exp answer got timeout");
         wrap_up();
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      tmo(n, 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // One link access: x is {seq, disp, ptr}; k link answers are awaited, then status lands in st.
   task automatic acc(input logic [2:0] md, input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic [8:0] x, input int k);
      logic [31:0] q;
      int n;
      wb(1'b1, 8'h00, {16'h0, a}, q);
      wb(1'b1, 8'h04, {1'b1, x[8], 10'h0, x[7:0], md, w, d}, q);
      n = 0;
      while (k > 0 && n < 100) begin
         @(posedge clk_i);
         n++;
         if (bus_if.ack === 1'b1)
            k--;
      end
      tmo(n, 100);
      wb(1'b0, 8'h08, 32'h0, st);
   endtask
   task automatic io(input logic w, input logic [5:0] i, input logic [7:0] d);
      acc(DMEE_M_IO, w, {10'h0, i}, d, 9'h0, 1);
   endtask
   task automatic dm(input logic w, input logic [15:0] a, input logic [7:0] d);
      acc(DMEE_M_DIRECT, w, a, d, 9'h0, 1);
   endtask
   task automatic t_map();
      logic [15:0] ma[6] = '{16'h0005, 16'h0030, 16'h0080, 16'h0100, 16'h02FF, 16'h0300};
      logic [7:0]  mv[6] = '{8'h3C, 8'h4B, 8'h69, 8'h5A, 8'h66, 8'h77};
      logic [7:0]  me[6] = '{8'h3C, 8'h4B, 8'h69, 8'h5A, 8'h66, 8'hFF};
      wb(1'b0, 8'h08, 32'h0, st);
      `CHK("stat_reset", 32'h0, st)
      wb(1'b0, 8'h0C, 32'h0, st);
      `CHK("wb_unmapped", 32'h0, st)
      for (int i = 0; i < 6; i++) begin
         dm(1'b1, ma[i], mv[i]);
         dm(1'b0, ma[i], 8'h00);
         `CHK("map_read", me[i], st[7:0])
      end
      // A short I/O access cannot reach past the standard I/O range, so no link access may follow.
      acc(DMEE_M_IO, 1'b0, 16'h0040, 8'h00, 9'h0, 0);
      `CHK("io_refused", 2'h2, st[9:8])
   endtask
   task automatic t_ptr();
      dm(1'b1, 16'h001C, 8'h10);
      dm(1'b1, 16'h001D, 8'h01);
      acc(DMEE_M_DISP, 1'b1, 16'h0, 8'hA5, {1'b0, 6'h3F, 2'h1}, 1);
      dm(1'b0, 16'h014F, 8'h00);
      `CHK("disp", 8'hA5, st[7:0])
      acc(DMEE_M_POSTINC, 1'b1, 16'h0, 8'h33, {1'b0, 6'h0, 2'h1}, 1);
      dm(1'b0, 16'h001C, 8'h00);
      `CHK("postinc", 8'h11, st[7:0])
      acc(DMEE_M_PREDEC, 1'b1, 16'h0, 8'h44, {1'b0, 6'h0, 2'h1}, 1);
      dm(1'b0, 16'h001C, 8'h00);
      `CHK("predec_ptr", 8'h10, st[7:0])
      dm(1'b0, 16'h0110, 8'h00);
      `CHK("predec_data", 8'h44, st[7:0])
      acc(DMEE_M_IND, 1'b0, 16'h0, 8'h00, {1'b0, 6'h0, 2'h1}, 1);
      `CHK("ind", 8'h44, st[7:0])
   endtask
   task automatic ee_wr(input logic [8:0] a, input logic [7:0] b, input logic [1:0] pm);
      int n;
      io(1'b1, 6'h21, a[7:0]);
      io(1'b1, 6'h22, {7'h7F, a[8]});
      io(1'b1, 6'h20, b);
      acc(DMEE_M_IO, 1'b1, 16'h001F, {2'h0, pm, 4'h2}, 9'h100, 2);
      `CHK("ee_busy", pm != 2'h3, busy)
      if (pm != 2'h3) begin
         // The address write below lands mid-write and must be dropped.
         io(1'b1, 6'h21, ~a[7:0]);
         io(1'b0, 6'h1F, 8'h00);
         `CHK("ee_strobe", 1'b1, st[1])
         n = 0;
         while (done !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
         end
         tmo(n, 200);
         io(1'b0, 6'h21, 8'h00);
         `CHK("ee_adr_held", a[7:0], st[7:0])
      end
   endtask
   task automatic t_ee();
      logic [7:0] bv[4] = '{8'hC3, 8'h0F, 8'h00, 8'h5A};
      logic [7:0] ev[4] = '{8'hC3, 8'h03, 8'hFF, 8'hFF};
      logic [1:0] pv[4] = '{2'h0, 2'h2, 2'h1, 2'h3};
      for (int i = 0; i < 4; i++) begin
         ee_wr(9'h134, bv[i], pv[i]);
         io(1'b1, 6'h1F, 8'h01);
         io(1'b0, 6'h20, 8'h00);
         `CHK("ee_data", ev[i], st[7:0])
      end
      io(1'b0, 6'h22, 8'h00);
      `CHK("ee_adr_hi", 8'h01, st[7:0])
      io(1'b1, 6'h1F, 8'h04);
      io(1'b1, 6'h1F, 8'h02);
      `CHK("ee_late_strobe", 1'b0, busy)
   endtask
   task automatic t_rst();
      acc(DMEE_M_IO, 1'b1, 16'h001F, 8'h02, 9'h100, 2);
      `CHK("rst_busy_pre", 1'b1, busy)
      // A reset in mid-write must cancel the write and bring both ends back to idle.
      rstn_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      `CHK("rst_busy", 1'b0, busy)
      wb(1'b0, 8'h08, 32'h0, st);
      `CHK("rst_stat", 32'h0, st)
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_map();
      t_ptr();
      t_ee();
      t_rst();
      wrap_up();
   end
endmodule // testbench
